/* bcsl_loader.sv */
// Boot code shadow loader with its control register, strap mirror and program address routing.
// How it works
// - after reset or reboot copy flash code to SRAMs before the CPU runs.
// - the synchronised shadow strap decides whether external SRAM is filled.
// - in shadow mode read block count from bits 6..0 of flash byte 0x3FFF.
// - each count unit means 32K bytes; software stores a covering count.
// - the lowest 16K bytes of flash always go to internal SRAM.
// - bit 7 of the configuration byte is read protection, not count.
// - the block count is handed to the memory arbiter.
// - writing 1 to bit 0 pulses CPU and peripheral reset, then self-clears.
// - writing 1 to bit 1 restarts the whole boot and EEPROM reload, self-clears.
// - with remap set, program 16K..32K reaches flash 0..16K, except in shadow mode with flash access clear.
// - with remap clear, 16K..32K is untranslated and 0..16K is internal SRAM.
// - shadow mode with flash access set sends 16K and above to flash.
// - shadow mode with flash access clear sends 16K and above to external SRAM.
// - read-only bit 4 mirrors the shadow strap.
// - read-only bit 5 mirrors the EEPROM boot disable strap.
// - read-only bits 7..6 mirror the clock select straps.
// - without shadow mode the count is ignored and only 16K is mirrored.
// - count N of 1..16 fills the lowest N times 32K of external SRAM.
// - byte pacing gives about 4.1 ms for the internal copy at 100 MHz.
// - debugger code download is allowed only when read protection bit is 1.
module bcsl_loader #(
  parameter int unsigned BYTE_PACE = bcsl_pkg::BYTE_PACE_CYC
) (
  // Clock, reset and clock enable.
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         ce,
  // APB slave.
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [bcsl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Strap pins.
  input  wire logic                         shadow_en_pin,
  input  wire logic                         eeprom_boot_dis_pin,
  input  wire logic [1:0]                   clock_select_strap,
  // On-chip flash read port.
  output logic                              flash_rd_req,
  output logic      [18:0]                  flash_addr,
  input  wire logic                         flash_rd_valid,
  input  wire logic [7:0]                   flash_rd_data,
  // Internal program SRAM write port.
  output logic                              isram_we,
  output logic      [13:0]                  isram_addr,
  output logic      [7:0]                   isram_wdata,
  // External program SRAM write port.
  output logic                              xsram_we,
  output logic      [18:0]                  xsram_addr,
  output logic      [7:0]                   xsram_wdata,
  // CPU and chip control.
  output logic                              cpu_hold,
  output logic                              cpu_reset_n,
  output logic                              periph_reset,
  output logic                              eeprom_reload,
  output logic                              debug_read_allow,
  // Memory arbiter.
  output logic      [6:0]                   block_count,
  input  wire logic [20:0]                  prog_addr,
  output logic                              prog_sel_isram,
  output logic                              prog_sel_flash,
  output logic                              prog_sel_xsram,
  output logic      [20:0]                  prog_flash_addr
);

  // The pace counter is eight bits wide.
  if (BYTE_PACE > 255) begin : g_bad_pace
    $error("BYTE_PACE must not exceed 255");
  end

  // All state lives in one record, so a single register process owns every flop.
  typedef struct packed {
    bcsl_pkg::bcsl_state_t st;
    logic [3:0]            wait_cnt;
    logic [7:0]            pace;
    logic [19:0]           cnt;
    logic [19:0]           ext_end;
    logic                  shadow_lat;
    logic [6:0]            blk;
    logic                  prot;
    logic                  ctrl_rst;
    logic                  ctrl_rbt;
    logic                  remap;
    logic                  fa_sh;
    logic [3:0]            rst_cnt;
    logic                  eep_reload;
    logic                  flash_req;
    logic [18:0]           flash_addr;
    logic                  isram_we;
    logic [13:0]           isram_addr;
    logic                  xsram_we;
    logic [18:0]           xsram_addr;
    logic [7:0]            wdata;
    logic [31:0]           prdata;
    logic [2:0]            sh_s;
    logic [2:0]            eep_s;
    logic [1:0]            clk_s0;
    logic [1:0]            clk_s1;
    logic [1:0]            clk_s2;
    logic                  sh_v;
    logic                  eep_v;
    logic [1:0]            clk_v;
  } bcsl_regs_t;

  bcsl_regs_t s_reg;
  bcsl_regs_t s_next;

  // Matches a byte address against a word index.
  function automatic logic addr_hit(input logic [bcsl_pkg::ADDR_W-1:0] a,
                                    input logic [9:0]                  idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction : addr_hit

  // Bytes to shadow externally; larger counts clamp to what the flash holds.
  function automatic logic [19:0] ext_len(input logic [6:0] n);
    logic [6:0] c;
    c = (n > bcsl_pkg::MAX_BLOCKS) ? bcsl_pkg::MAX_BLOCKS : n;
    ext_len = {c[4:0], 15'h0000};
  endfunction : ext_len

  // Bus decode helpers; the address match is exact, so misaligned offsets miss.
  logic apb_setup;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_stat;
  logic [7:0] ctrl_view;

  // Bus decode; pready follows ce so a frozen block stalls the master.
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && ce;
  assign hit_ctrl  = addr_hit(paddr, bcsl_pkg::CTRL_IDX);
  assign hit_stat  = addr_hit(paddr, bcsl_pkg::STAT_IDX);
  assign pready    = ce;
  assign pslverr   = psel && penable && !(hit_ctrl || hit_stat);
  assign ctrl_view = {s_reg.clk_v, s_reg.eep_v, s_reg.sh_v, s_reg.fa_sh,
                      s_reg.remap, s_reg.ctrl_rbt, s_reg.ctrl_rst};

  // Next-state logic for every register of the block.
  always_comb begin
    s_next            = s_reg;
    s_next.isram_we   = 1'b0;
    s_next.xsram_we   = 1'b0;
    s_next.eep_reload = 1'b0;

    // Straps pass three flops; a new level is taken once the last two agree.
    s_next.sh_s   = {s_reg.sh_s[1:0], shadow_en_pin};
    s_next.eep_s  = {s_reg.eep_s[1:0], eeprom_boot_dis_pin};
    s_next.clk_s0 = clock_select_strap;
    s_next.clk_s1 = s_reg.clk_s0;
    s_next.clk_s2 = s_reg.clk_s1;
    if (s_reg.sh_s[1] == s_reg.sh_s[2]) begin
      s_next.sh_v = s_reg.sh_s[2];
    end
    if (s_reg.eep_s[1] == s_reg.eep_s[2]) begin
      s_next.eep_v = s_reg.eep_s[2];
    end
    if (s_reg.clk_s1 == s_reg.clk_s2) begin
      s_next.clk_v = s_reg.clk_s2;
    end

    // Soft reset: the bit starts a fixed pulse and clears itself.
    if (s_reg.ctrl_rst) begin
      s_next.ctrl_rst = 1'b0;
      s_next.rst_cnt  = bcsl_pkg::RST_PULSE_CYC;
    end else if (s_reg.rst_cnt != 4'h0) begin
      s_next.rst_cnt = s_reg.rst_cnt - 4'h1;
    end

    // Loader sequence.
    case (s_reg.st)
      bcsl_pkg::ST_WAIT: begin
        // Give the strap synchronisers time to settle before sampling.
        s_next.wait_cnt = s_reg.wait_cnt + 4'h1;
        if (s_reg.wait_cnt == bcsl_pkg::SYNC_WAIT_CYC) begin
          s_next.shadow_lat = s_reg.sh_v;
          s_next.flash_addr = bcsl_pkg::CFG_ADDR;
          s_next.flash_req  = 1'b1;
          s_next.st         = bcsl_pkg::ST_CFG;
        end
      end
      bcsl_pkg::ST_CFG: begin
        // The configuration byte is read once per boot; a later change waits for a reboot.
        if (flash_rd_valid) begin
          s_next.flash_req = 1'b0;
          s_next.prot      = flash_rd_data[bcsl_pkg::PROT_BIT];
          // Without shadow mode the count is dropped altogether.
          if (s_reg.shadow_lat) begin
            s_next.blk     = flash_rd_data[bcsl_pkg::CNT_MSB:0];
            s_next.ext_end = ext_len(flash_rd_data[bcsl_pkg::CNT_MSB:0]);
          end else begin
            s_next.blk     = 7'h00;
            s_next.ext_end = 20'h00000;
          end
          s_next.cnt  = 20'h00000;
          s_next.pace = 8'(BYTE_PACE);
          s_next.st   = bcsl_pkg::ST_INT;
        end
      end
      bcsl_pkg::ST_INT, bcsl_pkg::ST_EXT: begin
        if (s_reg.flash_req) begin
          if (flash_rd_valid) begin
            s_next.flash_req = 1'b0;
            s_next.wdata     = flash_rd_data;
            s_next.pace      = 8'(BYTE_PACE);
            if (s_reg.st == bcsl_pkg::ST_INT) begin
              s_next.isram_we   = 1'b1;
              s_next.isram_addr = s_reg.flash_addr[13:0];
              if (s_reg.cnt == bcsl_pkg::INT_BYTES - 20'h1) begin
                s_next.cnt = 20'h00000;
                // A count of zero leaves the external SRAM untouched.
                if (s_reg.shadow_lat && s_reg.ext_end != 20'h00000) begin
                  s_next.st = bcsl_pkg::ST_EXT;
                end else begin
                  s_next.st = bcsl_pkg::ST_RUN;
                end
              end else begin
                s_next.cnt = s_reg.cnt + 20'h1;
              end
            end else begin
              s_next.xsram_we   = 1'b1;
              s_next.xsram_addr = s_reg.flash_addr;
              if (s_reg.cnt == s_reg.ext_end - 20'h1) begin
                s_next.st = bcsl_pkg::ST_RUN;
              end else begin
                s_next.cnt = s_reg.cnt + 20'h1;
              end
            end
          end
        end else if (s_reg.pace != 8'h00) begin
          // Idle cycles between reads set the overall load time; zero pacing is legal but fast.
          s_next.pace = s_reg.pace - 8'h01;
        end else begin
          s_next.flash_req  = 1'b1;
          s_next.flash_addr = s_reg.cnt[18:0];
        end
      end
      bcsl_pkg::ST_RUN: begin
        s_next.st = bcsl_pkg::ST_RUN;
      end
      default: begin
        s_next.st = bcsl_pkg::ST_WAIT;
      end
    endcase

    // Reboot clears remap and flash access, pulses the EEPROM reload and reruns the loader.
    if (s_reg.ctrl_rbt) begin
      s_next.ctrl_rbt   = 1'b0;
      s_next.st         = bcsl_pkg::ST_WAIT;
      s_next.wait_cnt   = 4'h0;
      s_next.flash_req  = 1'b0;
      s_next.remap      = 1'b0;
      s_next.fa_sh      = 1'b0;
      // A copy write launched in this cycle is dropped, so nothing lands after the restart.
      s_next.isram_we   = 1'b0;
      s_next.xsram_we   = 1'b0;
      s_next.eep_reload = 1'b1;
    end

    // Read data is captured in the setup phase so the access phase needs no wait.
    if (apb_setup) begin
      if (hit_ctrl) begin
        s_next.prdata = {24'h000000, ctrl_view};
      end else if (hit_stat) begin
        s_next.prdata = {17'h00000, s_reg.blk, 6'h00, s_reg.prot,
                         s_reg.st != bcsl_pkg::ST_RUN};
      end else begin
        s_next.prdata = 32'h00000000;
      end
    end

    // Writes come last so a set in the clearing cycle is not lost.
    if (apb_wr && hit_ctrl) begin
      if (pwdata[bcsl_pkg::B_SOFT_RST]) begin
        s_next.ctrl_rst = 1'b1;
      end
      if (pwdata[bcsl_pkg::B_REBOOT]) begin
        s_next.ctrl_rbt = 1'b1;
      end
      s_next.remap = pwdata[bcsl_pkg::B_REMAP];
      s_next.fa_sh = pwdata[bcsl_pkg::B_FLASH_SH];
    end
  end

  // State register; a low clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg        <= '0;
      s_reg.st     <= bcsl_pkg::ST_WAIT;
      s_reg.remap  <= bcsl_pkg::CTRL_RESET[bcsl_pkg::B_REMAP];
      s_reg.fa_sh  <= bcsl_pkg::CTRL_RESET[bcsl_pkg::B_FLASH_SH];
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Registered outputs.
  assign prdata           = s_reg.prdata;
  assign flash_rd_req     = s_reg.flash_req;
  assign flash_addr       = s_reg.flash_addr;
  assign isram_we         = s_reg.isram_we;
  assign isram_addr       = s_reg.isram_addr;
  assign isram_wdata      = s_reg.wdata;
  assign xsram_we         = s_reg.xsram_we;
  assign xsram_addr       = s_reg.xsram_addr;
  assign xsram_wdata      = s_reg.wdata;
  assign eeprom_reload    = s_reg.eep_reload;
  assign debug_read_allow = s_reg.prot;
  assign block_count      = s_reg.blk;
  assign periph_reset     = s_reg.rst_cnt != 4'h0;

  // The CPU waits for the final pending write, not just the last flash read.
  assign cpu_hold    = (s_reg.st != bcsl_pkg::ST_RUN) || s_reg.isram_we
                       || s_reg.xsram_we;
  assign cpu_reset_n = !cpu_hold && !periph_reset;

  logic low_16k;
  logic in_remap;
  logic to_xsram;

  // Program address routing for the arbiter; combinational so fetches see no added latency.
  assign low_16k         = prog_addr <= bcsl_pkg::ISRAM_TOP;
  assign in_remap        = (prog_addr >= bcsl_pkg::REMAP_LO) && (prog_addr <= bcsl_pkg::REMAP_HI);
  assign to_xsram        = !low_16k && s_reg.shadow_lat && !s_reg.fa_sh;
  assign prog_sel_isram  = low_16k;
  assign prog_sel_xsram  = to_xsram;
  assign prog_sel_flash  = !low_16k && !to_xsram;
  assign prog_flash_addr = (s_reg.remap && in_remap) ? prog_addr - bcsl_pkg::REMAP_LO
                                                     : prog_addr;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  // The CPU may only be let go in the cycle after the final copy write.
  release_after_copy_a: assert property ($fell(cpu_hold)
                                        |-> s_reg.st == bcsl_pkg::ST_RUN
                                        && ($past(isram_we) || $past(xsram_we)))
    else $error("CPU released before loading finished");
  ext_bound_a: assert property (xsram_we |-> {1'b0, xsram_addr} < s_reg.ext_end)
    else $error("external SRAM written beyond the block count");
  int_copy_data_a: assert property (isram_we |-> isram_wdata == $past(flash_rd_data)
                                   && isram_addr == $past(flash_addr[13:0]))
    else $error("internal SRAM write does not match flash byte");
  ext_needs_shadow_a: assert property (xsram_we |-> s_reg.shadow_lat && block_count != 7'h00)
    else $error("external SRAM written without shadow mode");
  cfg_byte_read_a: assert property (s_reg.st == bcsl_pkg::ST_CFG && flash_rd_req
                                   |-> flash_addr == 19'h03FFF)
    else $error("configuration read at wrong flash address");
  remap_translate_a: assert property (s_reg.remap && prog_addr == 21'h004123
                                     |-> prog_flash_addr == 21'h000123 && prog_sel_flash
                                     || prog_sel_xsram)
    else $error("remapped address not translated");
  low_to_isram_a: assert property (prog_addr < 21'h004000
                                  |-> prog_sel_isram && !prog_sel_flash && !prog_sel_xsram)
    else $error("low program space not routed to internal SRAM");
  shadow_route_a: assert property (s_reg.shadow_lat && prog_addr >= 21'h004000
                                  |-> prog_sel_xsram == !s_reg.fa_sh
                                  && prog_sel_flash == s_reg.fa_sh)
    else $error("shadow mode routing wrong");
  soft_reset_pulse_a: assert property ($rose(periph_reset) |-> periph_reset [*8] ##1 !periph_reset
                                      || s_reg.ctrl_rst)
    else $error("soft reset pulse length wrong");
  reboot_restart_a: assert property (eeprom_reload |-> s_reg.st == bcsl_pkg::ST_WAIT
                                    && cpu_hold && !s_reg.remap ##1 cpu_hold)
    else $error("reboot did not restart the loader");
  strap_mirror_a: assert property (psel && penable && hit_ctrl && $past(psel && !penable)
                                  |-> prdata[4] == $past(s_reg.sh_v)
                                  && prdata[7:6] == $past(s_reg.clk_v))
    else $error("strap bits not mirrored");

endmodule : bcsl_loader

/* bcsl_pkg.sv */
// Constants and the loader state encoding of the boot code shadow loader.
package bcsl_pkg;

  // APB register map: printed offsets are word indexes, byte address is four times that.
  localparam int unsigned   ADDR_W         = 12;
  localparam logic [9:0]    CTRL_IDX       = 10'h08F;
  localparam logic [9:0]    STAT_IDX       = 10'h090;
  localparam logic [7:0]    CTRL_RESET     = 8'h00;

  // Field positions of clock_reset_shadow_control.
  localparam int unsigned   B_SOFT_RST     = 0;
  localparam int unsigned   B_REBOOT       = 1;
  localparam int unsigned   B_REMAP        = 2;
  localparam int unsigned   B_FLASH_SH     = 3;

  // Field positions of the loader status register.
  localparam int unsigned   S_BUSY         = 0;
  localparam int unsigned   S_PROT         = 1;
  localparam int unsigned   S_CNT_LSB      = 8;

  // Flash configuration byte and memory layout.
  localparam logic [18:0]   CFG_ADDR       = 19'h03FFF;
  localparam int unsigned   CNT_MSB        = 6;
  localparam int unsigned   PROT_BIT       = 7;
  localparam logic [19:0]   INT_BYTES      = 20'h04000;
  localparam int unsigned   BLOCK_SHIFT    = 15;
  localparam logic [6:0]    MAX_BLOCKS     = 7'h10;
  localparam logic [20:0]   ISRAM_TOP      = 21'h003FFF;
  localparam logic [20:0]   REMAP_LO       = 21'h004000;
  localparam logic [20:0]   REMAP_HI       = 21'h007FFF;

  // Timing: internal-only mirroring takes about this long at the nominal clock.
  localparam int unsigned   CLK_PERIOD_NS  = 10;
  localparam int unsigned   INT_LOAD_NS    = 4_100_000;
  localparam int unsigned   BYTE_PACE_CYC  = INT_LOAD_NS / CLK_PERIOD_NS / 16384;
  localparam logic [3:0]    RST_PULSE_CYC  = 4'h8;
  localparam logic [3:0]    SYNC_WAIT_CYC  = 4'h4;

  // Loader sequence, one-hot.
  typedef enum logic [4:0] {
    ST_WAIT = 5'h01,
    ST_CFG  = 5'h02,
    ST_INT  = 5'h04,
    ST_EXT  = 5'h08,
    ST_RUN  = 5'h10
  } bcsl_state_t;

endpackage : bcsl_pkg

/* bcsl_flash_model.sv */
// Behavioural on-chip flash read port that answers the loader one byte per request.
module bcsl_flash_model (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Content and pace set by the bench.
  input  wire logic [7:0]  cfg_byte,
  input  wire logic        slow,
  // Read port.
  input  wire logic        flash_rd_req,
  input  wire logic [18:0] flash_addr,
  output logic             flash_rd_valid,
  output logic [7:0]       flash_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [1:0] wait_cnt;

  // Content is a scramble of the address, so a wrong address shows as wrong data.
  function automatic logic [7:0] byte_at(input logic [18:0] a);
    return (a == 19'h03FFF) ? cfg_byte : (a[7:0] ^ a[15:8] ^ {a[18:16], 5'h00});
  endfunction : byte_at

  // One answer per request; slow mode adds two wait cycles.
  // Idle data toggles every cycle so that a sample one cycle late sees the inverted byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_rd_valid <= 1'b0;
      flash_rd_data  <= 8'h00;
      wait_cnt       <= 2'h0;
    end else if (flash_rd_req && !flash_rd_valid && (!slow || wait_cnt == 2'h2)) begin
      flash_rd_valid <= 1'b1;
      flash_rd_data  <= byte_at(flash_addr);
      wait_cnt       <= 2'h0;
    end else begin
      flash_rd_valid <= 1'b0;
      flash_rd_data  <= ~flash_rd_data;
      wait_cnt       <= (flash_rd_req && !flash_rd_valid) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule : bcsl_flash_model

/* testbench.sv */
// Self-checking bench for the boot code shadow loader with a flash model.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [11:0] CTRL_A = {bcsl_pkg::CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {bcsl_pkg::STAT_IDX, 2'b00};
  localparam int          LIM    = 200000;
  logic        pclk, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic        presetn = 0, ce = 1, shadow_en_pin = 1, eeprom_boot_dis_pin = 1, slow = 0;
  logic [1:0]  clock_select_strap = 2'b11;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [7:0]  cfg_byte = 8'h81, flash_rd_data, isram_wdata, xsram_wdata;
  logic [18:0] flash_addr, xsram_addr;
  logic [13:0] isram_addr;
  logic        flash_rd_req, flash_rd_valid, isram_we, xsram_we, cpu_hold, cpu_reset_n;
  logic        periph_reset, eeprom_reload, debug_read_allow;
  logic        prog_sel_isram, prog_sel_flash, prog_sel_xsram;
  logic [6:0]  block_count;
  logic [20:0] prog_addr = 0, prog_flash_addr;
  int          error_cnt = 0, total_checks = 0, n_int = 0, n_ext = 0, n_reload = 0, i, k;

  bcsl_loader #(.BYTE_PACE(0)) bcsl_loader_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shadow_en_pin(shadow_en_pin), .eeprom_boot_dis_pin(eeprom_boot_dis_pin),
    .clock_select_strap(clock_select_strap), .flash_rd_req(flash_rd_req),
    .flash_addr(flash_addr), .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data),
    .isram_we(isram_we), .isram_addr(isram_addr), .isram_wdata(isram_wdata),
    .xsram_we(xsram_we), .xsram_addr(xsram_addr), .xsram_wdata(xsram_wdata),
    .cpu_hold(cpu_hold), .cpu_reset_n(cpu_reset_n), .periph_reset(periph_reset),
    .eeprom_reload(eeprom_reload), .debug_read_allow(debug_read_allow),
    .block_count(block_count), .prog_addr(prog_addr), .prog_sel_isram(prog_sel_isram),
    .prog_sel_flash(prog_sel_flash), .prog_sel_xsram(prog_sel_xsram),
    .prog_flash_addr(prog_flash_addr));

  bcsl_flash_model bcsl_flash_model_i (
    .pclk(pclk), .presetn(presetn), .cfg_byte(cfg_byte), .slow(slow),
    .flash_rd_req(flash_rd_req), .flash_addr(flash_addr),
    .flash_rd_valid(flash_rd_valid), .flash_rd_data(flash_rd_data));

  // Free-running system clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // A wait that ran out of cycles ends the run as a failure.
  task automatic tmo(input int n);
    if (n >= LIM) begin
      error_cnt++;
      end_of_test();
    end
  endtask : tmo

  // One APB transfer; read data and error flag are taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < LIM; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    tmo(k);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Drive a program address and compare the routing one cycle later.
  task automatic route(input logic [20:0] a, input logic [2:0] sel, input logic [20:0] fa);
    @(posedge pclk);
    prog_addr <= a;
    @(posedge pclk);
    chk({prog_sel_isram, prog_sel_flash, prog_sel_xsram, sel[1] ? prog_flash_addr : 21'h0},
        {sel, fa});
  endtask : route

  // Every copy write must carry the flash byte of its address, in order; internal writes with the CPU held, external ones after all 16384 internal.
  always @(posedge pclk) begin
    if (eeprom_reload === 1'b1) begin
      n_int = 0;
      n_ext = 0;
      n_reload++;
    end
    if (isram_we === 1'b1) begin
      chk({isram_addr, isram_wdata}, {n_int[13:0], bcsl_flash_model_i.byte_at(n_int[18:0])});
      chk({cpu_hold, cpu_reset_n}, 2'b10);
      n_int++;
    end
    if (xsram_we === 1'b1) begin
      chk({xsram_addr, xsram_wdata}, {n_ext[18:0], bcsl_flash_model_i.byte_at(n_ext[18:0])});
      chk(n_int, 32'd16384);
      n_ext++;
    end
  end

  // Main sequence: shadow boot, reboot in mid-copy, plain boot, routing and soft reset.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'hF0);
    apb(1'b1, CTRL_A, 32'h0C);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'hFC);
    route(21'h000010, 3'b100, 21'h0);
    route(21'h004123, 3'b010, 21'h000123);
    route(21'h008000, 3'b010, 21'h008000);
    apb(1'b1, CTRL_A, 32'h00);
    route(21'h004010, 3'b001, 21'h0);
    for (i = 0; i < LIM && n_ext < 4; i++) @(posedge pclk);
    tmo(i);
    chk({cpu_hold, debug_read_allow, block_count}, {2'b11, 7'h01});
    apb(1'b0, STAT_A, 32'h0);
    chk(rd, 32'h0000_0103);
    shadow_en_pin       <= 1'b0;
    eeprom_boot_dis_pin <= 1'b0;
    clock_select_strap  <= 2'b01;
    cfg_byte            <= 8'h05;
    slow                <= 1'b1;
    apb(1'b1, CTRL_A, 32'h0E);
    repeat (200) @(posedge pclk);
    slow <= 1'b0;
    chk(n_reload, 32'd1);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'h40);
    for (i = 0; i < LIM && cpu_hold !== 1'b0; i++) @(posedge pclk);
    tmo(i);
    chk(n_int, 32'd16384);
    chk(n_ext, 32'd0);
    chk({debug_read_allow, block_count, cpu_reset_n}, {1'b0, 7'h00, 1'b1});
    route(21'h004010, 3'b010, 21'h004010);
    route(21'h009000, 3'b010, 21'h009000);
    apb(1'b1, CTRL_A, 32'h04);
    route(21'h004123, 3'b010, 21'h000123);
    route(21'h000010, 3'b100, 21'h0);
    apb(1'b1, CTRL_A, 32'h05);
    // Freeze the block for ten cycles inside the pulse: it must stretch by exactly that much.
    i = 0;
    for (k = 0; k < 30; k++) begin
      @(posedge pclk);
      if (periph_reset === 1'b1) i++;
      ce <= !(k >= 4 && k < 14);
    end
    chk(i, 32'h12);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'h44);
    chk({n_reload[3:0], cpu_hold}, {4'h1, 1'b0});
    apb(1'b0, 12'h100, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    end_of_test();
  end
endmodule : testbench
